/* pkg/flash_selftest_defines.svh */
/*
 * Constants of the serial flash self-test sequencer: target addresses,
 * test bytes, step counts, build defaults and power-up timing.
 * Assumes it is included once per file by its bare name.
 */
`ifndef FLASH_SELFTEST_DEFINES_SVH
`define FLASH_SELFTEST_DEFINES_SVH

// Build defaults
`define FST_ADDR_W_DEFAULT 24
`define FST_ADDR_W_WIDE 32
`define FST_SCLK_DIV_DEFAULT 2

// Core clock and settle time before the first command
`define FST_CLK_PERIOD_NS 10
`define FST_PWRUP_NS 1000

// Target addresses
`define FST_ADDR_STEP_A 32'h0035_0000
`define FST_ADDR_STEP_B 32'h0000_0004
`define FST_ADDR_WAKE 32'h0005_0000
`define FST_ADDR_STEP_C 32'h0000_00ff
`define FST_ADDR_STEP_D 32'h0000_0024
`define FST_ADDR_QUAD 32'h0000_0010

// Test bytes
`define FST_DATA_A 8'h5a
`define FST_DATA_B 8'h33
`define FST_DATA_C 8'h50
`define FST_DATA_D 8'h23
`define FST_DATA_QUAD 8'hc3

// Sequence length
`define FST_STEPS_BASE 5'h0e
`define FST_STEPS_QUAD 5'h12

`endif

/* pkg/flash_selftest_pkg.sv */
/*
 * Types of the serial flash self-test sequencer: controller commands,
 * sequencer states and one step of the fixed test sequence.
 * Assumes nothing of its surroundings.
 */
package flash_selftest_pkg;

	typedef enum logic [3:0] {
		CMD_NONE,
		CMD_SOFT_RESET,
		CMD_SECTOR_ERASE,
		CMD_BLOCK_ERASE,
		CMD_PAGE_WRITE,
		CMD_QUAD_WRITE,
		CMD_RELEASE_PD,
		CMD_READ,
		CMD_FAST_READ,
		CMD_FAST_READ_DUAL,
		CMD_FAST_READ_QUAD
	} cmd_t;

	typedef enum logic [3:0] {
		S_POWERUP,
		S_SETUP,
		S_QUAD_PULSE,
		S_QUAD_WAIT,
		S_ISSUE,
		S_WAIT_START,
		S_WAIT_DONE,
		S_NEXT,
		S_DONE
	} seq_state_t;

	typedef struct packed {
		cmd_t cmd;
		logic [31:0] addr;
		logic [7:0] data;
		logic four_byte;
	} step_t;

endpackage : flash_selftest_pkg

/* hw/sclk_tick.sv */
/*
 * Divider that yields a one-cycle tick every DIV core clocks; the parent
 * toggles the serial clock on each tick.
 * Assumes one core clock and a synchronous active-high reset.
 */
module sclk_tick #(
	parameter int DIV = 2
) (
	input wire logic clk,
	input wire logic reset,
	output logic tick_r
);
	localparam int CW = $clog2(DIV + 1);
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);

	logic [CW-1:0] cnt_r;

	always_ff @(posedge clk) begin
		if (reset) begin
			cnt_r <= '0;
			tick_r <= 1'b0;
		end else if (cnt_r == LAST) begin
			cnt_r <= '0;
			tick_r <= 1'b1;
		end else begin
			cnt_r <= cnt_r + CW'(1);
			tick_r <= 1'b0;
		end
	end

endmodule : sclk_tick

/* hw/flash_selftest_seq.sv */
/*
 * Power-up self-test sequencer for a serial flash controller core: erase,
 * write and read back fixed bytes in single, dual and optional quad modes,
 * then light the indicator LEDs if every byte read back matched.
 * Assumes the controller raises busy the cycle after cmd_start_r and keeps
 * it high until the operation ends; read bytes arrive with rd_valid.
 */
`include "flash_selftest_defines.svh"

// Summary of operation
// - Address width 24 or 32, default 24
// - Serial clock is core clock over twice divider
// - Reset, then erase/write/fast-read 0x5a at 0x350000
// - Erase/write/dual-read 0x33 at 0x000004
// - Release power-down at address 0x050000
// - Block erase/write/dual-read 0x50 at 0x0000ff
// - Block erase/write/fast-read 0x23 at 0x000024
// - Mixed variant: four-byte at 0x350000, 0x0000ff
// - Quad: erase, quad write, read, quad read
// - Light LEDs when whole sequence completes with no miss
module flash_selftest_seq #(
	parameter int ADDR_W = `FST_ADDR_W_DEFAULT,
	parameter int SCLK_DIV = `FST_SCLK_DIV_DEFAULT,
	parameter bit QUAD_EN = 1'b0,
	parameter bit MIXED_ADDR = 1'b0
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic busy,
	input wire logic rd_valid,
	input wire logic [7:0] rd_data,
	output flash_selftest_pkg::cmd_t cmd_r,
	output logic cmd_start_r,
	output logic [ADDR_W-1:0] addr_r,
	output logic [7:0] wr_data_r,
	output logic four_byte_r,
	output logic rden_r,
	output logic quad_en_r,
	output logic sclk_r,
	output logic done_r,
	output logic fail_r,
	output logic [1:0] led_r
);
	import flash_selftest_pkg::*;

	localparam int PWRUP_CYC =
		(`FST_PWRUP_NS + `FST_CLK_PERIOD_NS - 1) / `FST_CLK_PERIOD_NS;
	localparam logic [7:0] PWRUP_LAST = 8'(PWRUP_CYC - 1);
	localparam logic [4:0] LAST_STEP =
		QUAD_EN ? `FST_STEPS_QUAD - 5'h01 : `FST_STEPS_BASE - 5'h01;

	seq_state_t state_r;
	logic [4:0] step_r;
	logic [7:0] pwr_cnt_r;
	logic got_byte_r;
	logic tick;
	step_t cur;

	function automatic step_t step_of(input logic [4:0] idx);
		step_t s;
		s = '{CMD_NONE, 32'h0000_0000, 8'h00, 1'b0};
		unique case (idx)
			5'h00: s = '{CMD_SOFT_RESET, 32'h0000_0000, 8'h00, 1'b0};
			5'h01: s = '{CMD_SECTOR_ERASE, `FST_ADDR_STEP_A, 8'h00, MIXED_ADDR};
			5'h02: s = '{CMD_PAGE_WRITE, `FST_ADDR_STEP_A, `FST_DATA_A,
				MIXED_ADDR};
			5'h03: s = '{CMD_FAST_READ, `FST_ADDR_STEP_A, `FST_DATA_A,
				MIXED_ADDR};
			5'h04: s = '{CMD_SECTOR_ERASE, `FST_ADDR_STEP_B, 8'h00, 1'b0};
			5'h05: s = '{CMD_PAGE_WRITE, `FST_ADDR_STEP_B, `FST_DATA_B, 1'b0};
			5'h06: s = '{CMD_FAST_READ_DUAL, `FST_ADDR_STEP_B, `FST_DATA_B,
				1'b0};
			5'h07: s = '{CMD_RELEASE_PD, `FST_ADDR_WAKE, 8'h00, 1'b0};
			5'h08: s = '{CMD_BLOCK_ERASE, `FST_ADDR_STEP_C, 8'h00, MIXED_ADDR};
			5'h09: s = '{CMD_PAGE_WRITE, `FST_ADDR_STEP_C, `FST_DATA_C,
				MIXED_ADDR};
			5'h0a: s = '{CMD_FAST_READ_DUAL, `FST_ADDR_STEP_C, `FST_DATA_C,
				MIXED_ADDR};
			5'h0b: s = '{CMD_BLOCK_ERASE, `FST_ADDR_STEP_D, 8'h00, 1'b0};
			5'h0c: s = '{CMD_PAGE_WRITE, `FST_ADDR_STEP_D, `FST_DATA_D, 1'b0};
			5'h0d: s = '{CMD_FAST_READ, `FST_ADDR_STEP_D, `FST_DATA_D,
				1'b0};
			5'h0e: s = '{CMD_SECTOR_ERASE, `FST_ADDR_QUAD, 8'h00, 1'b0};
			5'h0f: s = '{CMD_QUAD_WRITE, `FST_ADDR_QUAD, `FST_DATA_QUAD, 1'b0};
			5'h10: s = '{CMD_READ, `FST_ADDR_QUAD, `FST_DATA_QUAD, 1'b0};
			5'h11: s = '{CMD_FAST_READ_QUAD, `FST_ADDR_QUAD, `FST_DATA_QUAD,
				1'b0};
			default: s = '{CMD_NONE, 32'h0000_0000, 8'h00, 1'b0};
		endcase
		return s;
	endfunction : step_of

	function automatic logic is_read(input cmd_t c);
		return c inside {CMD_READ, CMD_FAST_READ, CMD_FAST_READ_DUAL,
			CMD_FAST_READ_QUAD};
	endfunction : is_read

	always_comb begin
		cur = step_of(step_r);
	end

	sclk_tick #(
		.DIV(SCLK_DIV)
	) u_sclk_tick (
		.clk(clk),
		.reset(reset),
		.tick_r(tick)
	);

	// Half period of SCLK_DIV core cycles
	always_ff @(posedge clk) begin
		if (reset)
			sclk_r <= 1'b0;
		else if (tick)
			sclk_r <= ~sclk_r;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state_r <= S_POWERUP;
			step_r <= 5'h00;
			pwr_cnt_r <= 8'h00;
		end else begin
			unique case (state_r)
				S_POWERUP: begin
					if (pwr_cnt_r == PWRUP_LAST)
						state_r <= S_SETUP;
					else
						pwr_cnt_r <= pwr_cnt_r + 8'h01;
				end
				S_SETUP: begin
					if (cur.cmd == CMD_FAST_READ_QUAD)
						state_r <= S_QUAD_PULSE;
					else
						state_r <= S_ISSUE;
				end
				S_QUAD_PULSE: state_r <= S_QUAD_WAIT;
				S_QUAD_WAIT: begin
					if (!busy)
						state_r <= S_ISSUE;
				end
				S_ISSUE: state_r <= S_WAIT_START;
				S_WAIT_START: begin
					if (busy)
						state_r <= S_WAIT_DONE;
				end
				S_WAIT_DONE: begin
					if (!busy)
						state_r <= S_NEXT;
				end
				S_NEXT: begin
					if (step_r == LAST_STEP) begin
						state_r <= S_DONE;
					end else begin
						step_r <= step_r + 5'h01;
						state_r <= S_SETUP;
					end
				end
				S_DONE: state_r <= S_DONE;
			endcase
		end
	end

	// Address and data settle at least one cycle ahead of the command strobe
	always_ff @(posedge clk) begin
		if (reset) begin
			cmd_r <= CMD_NONE;
			addr_r <= '0;
			wr_data_r <= 8'h00;
			four_byte_r <= 1'b0;
		end else if (state_r == S_SETUP) begin
			cmd_r <= cur.cmd;
			addr_r <= cur.addr[ADDR_W-1:0];
			wr_data_r <= cur.data;
			four_byte_r <= cur.four_byte;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			cmd_start_r <= 1'b0;
			quad_en_r <= 1'b0;
		end else begin
			// Strobe one cycle after setup so the address already stands
			cmd_start_r <= state_r == S_ISSUE;
			quad_en_r <= state_r == S_SETUP && cur.cmd == CMD_FAST_READ_QUAD;
		end
	end

	// Read enable held for the whole read, dropped as busy falls
	always_ff @(posedge clk) begin
		if (reset)
			rden_r <= 1'b0;
		else if (state_r == S_ISSUE && is_read(cmd_r))
			rden_r <= 1'b1;
		else if (state_r == S_WAIT_DONE && !busy)
			rden_r <= 1'b0;
	end

	// A read that delivers no byte at all counts as a miss
	always_ff @(posedge clk) begin
		if (reset) begin
			fail_r <= 1'b0;
			got_byte_r <= 1'b0;
		end else begin
			if (state_r == S_ISSUE)
				got_byte_r <= 1'b0;
			else if (rd_valid && rden_r)
				got_byte_r <= 1'b1;
			if (rd_valid && rden_r && rd_data != wr_data_r)
				fail_r <= 1'b1;
			if (state_r == S_NEXT && is_read(cmd_r) && !got_byte_r)
				fail_r <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			done_r <= 1'b0;
			led_r <= 2'b00;
		end else if (state_r == S_DONE) begin
			done_r <= 1'b1;
			led_r <= fail_r ? 2'b00 : 2'b11;
		end
	end

	chk_addr_width: assert property (@(posedge clk)
		ADDR_W == `FST_ADDR_W_DEFAULT || ADDR_W == `FST_ADDR_W_WIDE)
		else $error("address width neither 24 nor 32");

	chk_sclk_half: assert property (@(posedge clk) disable iff (reset)
		$rose(sclk_r) |-> ##SCLK_DIV $fell(sclk_r))
		else $error("serial clock half period wrong");

	chk_step_idle: assert property (@(posedge clk) disable iff (reset)
		cmd_start_r && step_r != 5'h00 |-> $past(!busy, 2) || $past(!busy))
		else $error("step started while busy");

	chk_first_reset: assert property (@(posedge clk) disable iff (reset)
		cmd_start_r && step_r == 5'h00 |-> cmd_r == CMD_SOFT_RESET)
		else $error("first step is not soft reset");

	chk_write_a: assert property (@(posedge clk) disable iff (reset)
		cmd_start_r && step_r == 5'h02 |-> cmd_r == CMD_PAGE_WRITE
		&& wr_data_r == `FST_DATA_A && addr_r == ADDR_W'(`FST_ADDR_STEP_A))
		else $error("first write wrong");

	chk_dual_read_b: assert property (@(posedge clk) disable iff (reset)
		cmd_start_r && step_r == 5'h06 |-> cmd_r == CMD_FAST_READ_DUAL
		&& addr_r == ADDR_W'(`FST_ADDR_STEP_B) && !four_byte_r)
		else $error("dual read at 0x000004 wrong");

	chk_wake_addr: assert property (@(posedge clk) disable iff (reset)
		cmd_start_r && step_r == 5'h07 |-> cmd_r == CMD_RELEASE_PD
		&& addr_r == ADDR_W'(`FST_ADDR_WAKE))
		else $error("power-down release wrong");

	chk_write_c: assert property (@(posedge clk) disable iff (reset)
		cmd_start_r && step_r == 5'h09 |-> wr_data_r == `FST_DATA_C
		&& four_byte_r == MIXED_ADDR)
		else $error("write at 0x0000ff wrong");

	chk_read_d: assert property (@(posedge clk) disable iff (reset)
		cmd_start_r && step_r == 5'h0d |-> cmd_r == CMD_FAST_READ
		&& addr_r == ADDR_W'(`FST_ADDR_STEP_D))
		else $error("fast read at 0x000024 wrong");

	chk_quad_pulse: assert property (@(posedge clk) disable iff (reset)
		quad_en_r |=> !quad_en_r ##[0:1000] cmd_start_r
		&& cmd_r == CMD_FAST_READ_QUAD)
		else $error("quad enable not one pulse before quad read");

	chk_addr_ahead: assert property (@(posedge clk) disable iff (reset)
		cmd_start_r |-> $stable(addr_r))
		else $error("address changed with command");

	chk_led_pass: assert property (@(posedge clk) disable iff (reset)
		done_r |-> led_r == (fail_r ? 2'b00 : 2'b11))
		else $error("LEDs disagree with test result");

endmodule : flash_selftest_seq

/* bench/ctrl_model.sv */
/*
 * Behavioural flash controller facing the self-test sequencer, with a
 * byte store so that reads return what was written after an erase.
 * Assumes one core clock and the sequencer's start/busy handshake.
 */
module ctrl_model
	import flash_selftest_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire cmd_t cmd,
	input wire logic start,
	input wire logic [31:0] addr,
	input wire logic [7:0] wr_data,
	input wire logic slow,
	input wire logic corrupt,
	output logic busy,
	output logic rd_valid,
	output logic [7:0] rd_data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [logic [31:0]];
	logic [5:0] cnt_r;
	logic rd_r;

	always @(posedge clk) begin
		rd_valid <= 1'b0;
		// Data line inverts every cycle outside a valid cycle, so it holds the last byte only on alternate cycles
		rd_data <= ~rd_data;
		if (reset) begin
			busy <= 1'b0;
			cnt_r <= 6'h00;
			rd_data <= 8'h00;
		end else if (start) begin
			busy <= 1'b1;
			cnt_r <= slow ? 6'h28 : 6'h04;
			rd_r <= cmd inside {CMD_READ, CMD_FAST_READ,
				CMD_FAST_READ_DUAL, CMD_FAST_READ_QUAD};
			case (cmd)
			CMD_SECTOR_ERASE, CMD_BLOCK_ERASE: mem[addr] = 8'hff;
			CMD_PAGE_WRITE, CMD_QUAD_WRITE: mem[addr] = wr_data;
			default: ;
			endcase
		end else if (cnt_r != 6'h00) begin
			cnt_r <= cnt_r - 6'h01;
			if (cnt_r == 6'h02 && rd_r) begin
				rd_valid <= 1'b1;
				rd_data <= (mem.exists(addr) ? mem[addr] : 8'hff) ^
					{7'h00, corrupt};
			end
			if (cnt_r == 6'h01)
				busy <= 1'b0;
		end
	end
endmodule : ctrl_model

/* bench/testbench.sv */
/*
 * Self-checking bench: full test sequence against the controller model,
 * fast, slow and with corrupted reads; checks order, LEDs, serial clock.
 * Assumes the package, design and model are compiled before it.
 */
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import flash_selftest_pkg::*;

	localparam int DIV = 2;
	localparam step_t EXP [18] = '{
		'{CMD_SOFT_RESET, 32'h0000_0000, 8'h00, 1'b0},
		'{CMD_SECTOR_ERASE, 32'h0035_0000, 8'h00, 1'b1},
		'{CMD_PAGE_WRITE, 32'h0035_0000, 8'h5a, 1'b1},
		'{CMD_FAST_READ, 32'h0035_0000, 8'h5a, 1'b1},
		'{CMD_SECTOR_ERASE, 32'h0000_0004, 8'h00, 1'b0},
		'{CMD_PAGE_WRITE, 32'h0000_0004, 8'h33, 1'b0},
		'{CMD_FAST_READ_DUAL, 32'h0000_0004, 8'h33, 1'b0},
		'{CMD_RELEASE_PD, 32'h0005_0000, 8'h00, 1'b0},
		'{CMD_BLOCK_ERASE, 32'h0000_00ff, 8'h00, 1'b1},
		'{CMD_PAGE_WRITE, 32'h0000_00ff, 8'h50, 1'b1},
		'{CMD_FAST_READ_DUAL, 32'h0000_00ff, 8'h50, 1'b1},
		'{CMD_BLOCK_ERASE, 32'h0000_0024, 8'h00, 1'b0},
		'{CMD_PAGE_WRITE, 32'h0000_0024, 8'h23, 1'b0},
		'{CMD_FAST_READ, 32'h0000_0024, 8'h23, 1'b0},
		'{CMD_SECTOR_ERASE, 32'h0000_0010, 8'h00, 1'b0},
		'{CMD_QUAD_WRITE, 32'h0000_0010, 8'hc3, 1'b0},
		'{CMD_READ, 32'h0000_0010, 8'hc3, 1'b0},
		'{CMD_FAST_READ_QUAD, 32'h0000_0010, 8'hc3, 1'b0}};

	logic clk = 1'b0;
	logic reset = 1'b1;
	logic slow = 1'b0;
	logic corrupt = 1'b0;
	logic busy, rd_valid, cmd_start_r, four_byte_r, rden_r;
	logic quad_en_r, sclk_r, done_r, fail_r;
	logic [7:0] rd_data, wr_data_r;
	logic [31:0] addr_r;
	logic [31:0] addr_q;
	logic [1:0] led_r;
	cmd_t cmd_r;
	step_t log_q [$];
	int num_errors = 0;
	int checks = 0;
	int quad_n = 0;

	flash_selftest_seq #(.ADDR_W(32), .SCLK_DIV(DIV), .QUAD_EN(1'b1),
		.MIXED_ADDR(1'b1)) dut (.clk(clk), .reset(reset), .busy(busy),
		.rd_valid(rd_valid), .rd_data(rd_data), .cmd_r(cmd_r),
		.cmd_start_r(cmd_start_r), .addr_r(addr_r),
		.wr_data_r(wr_data_r), .four_byte_r(four_byte_r),
		.rden_r(rden_r), .quad_en_r(quad_en_r), .sclk_r(sclk_r),
		.done_r(done_r), .fail_r(fail_r), .led_r(led_r));

	ctrl_model model (.clk(clk), .reset(reset), .cmd(cmd_r),
		.start(cmd_start_r), .addr(addr_r), .wr_data(wr_data_r),
		.slow(slow), .corrupt(corrupt), .busy(busy),
		.rd_valid(rd_valid), .rd_data(rd_data));

	always #5 clk = ~clk;

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic final_report();
		$display("checks %0d num_errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : final_report

	always @(posedge clk) begin
		if (cmd_start_r === 1'b1) begin
			log_q.push_back('{cmd_r, addr_r, wr_data_r, four_byte_r});
			check(busy, 1'b0);
			check(addr_r, addr_q);
		end
		if (rd_valid === 1'b1)
			check(rden_r, 1'b1);
		if (quad_en_r === 1'b1) begin
			quad_n++;
			check(cmd_r, CMD_FAST_READ_QUAD);
		end
		if (done_r !== 1'b1 && led_r !== 2'b00)
			check(led_r, 2'b00);
		// Address of the previous cycle, to see it stood before the strobe
		addr_q = addr_r;
	end

	// Whole run under one speed and read fault setting
	task automatic run_seq(input logic s, input logic c);
		int i;
		slow <= s;
		corrupt <= c;
		reset <= 1'b1;
		repeat (4) @(posedge clk);
		check({cmd_start_r, quad_en_r, done_r, fail_r, led_r}, 6'h00);
		reset <= 1'b0;
		log_q.delete();
		quad_n = 0;
		i = 0;
		while (done_r !== 1'b1 && i < 5000) begin
			@(posedge clk);
			i++;
		end
		if (i >= 5000) begin
			num_errors++;
			final_report();
		end
		check(led_r, c ? 2'b00 : 2'b11);
		check(fail_r, c);
		// Linger to see that nothing more is issued
		repeat (30) @(posedge clk);
		check(done_r, 1'b1);
		check(quad_n, 1);
		check(log_q.size(), 18);
		for (int k = 0; k < 18 && k < log_q.size(); k++)
			check(log_q[k], EXP[k]);
	endtask : run_seq

	task automatic check_sclk();
		logic prev;
		int n;
		int k;
		n = -1000;
		k = 0;
		prev = sclk_r;
		for (int i = 0; i < 40; i++) begin
			@(posedge clk);
			n++;
			if (sclk_r !== prev) begin
				if (n > 0) begin
					check(n, DIV);
					k++;
				end
				n = 0;
				prev = sclk_r;
			end
		end
		check(k > 4, 1'b1);
	endtask : check_sclk

	initial begin
		run_seq(1'b0, 1'b0);
		check_sclk();
		run_seq(1'b1, 1'b0);
		run_seq(1'b0, 1'b1);
		final_report();
	end
endmodule : testbench
